/* core/ctsf_framer.sv */
// Completion stream framer: accepts user completion beats and presents them
// to the core with one uniform framing form, whether straddle is on or off.
// Assumes the sender holds data stable while ready is low, and that the
// straddle selection changes only between TLPs.
//
// Overview of operation
// - With straddle the start flags mean none, one or two TLPs beginning, with code 10 reserved.
// - The start flags are used only with straddle; otherwise a first beat is the one after a last beat.
// - The first start position is lane 0 for code 00 and lane 32 for code 10, the others reserved.
// - The second start position is used only with straddle and must be 10, meaning lane 32.
// - The end flags mark the last beat of each TLP, meaning none, one or two ending, with 10 reserved.
// - Without straddle the end flags are ignored and the end comes from last and the keep bits.
// - The first end offset gives the last Dword of the first TLP ending, valid with end bit 0.
// - The second end offset gives the last Dword of the second TLP ending, valid with end bit 1.
// - With straddle the last signal is disregarded and only the sideband flags frame TLPs.
module ctsf_framer
   import ctsf_pkg::*;
#(
   parameter int DATA_WIDTH = DATA_W,
   parameter int KEEP_WIDTH = KEEP_W
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst_b,
   // Mode
   input  wire logic                    straddleEn,
   // Completion stream from user logic
   input  wire logic [DATA_WIDTH-1:0]   s_axis_cc_tdata,
   input  wire logic [KEEP_WIDTH-1:0]   s_axis_cc_tkeep,
   input  wire logic                    s_axis_cc_tlast,
   input  wire logic                    s_axis_cc_tvalid,
   input  wire logic [SIDEBAND_W-1:0]   completionSideband,
   output logic [3:0]                   s_axis_cc_tready,
   // Framed beats towards the core
   output logic                         beatValid,
   input  wire logic                    beatReady,
   output logic [DATA_WIDTH-1:0]        beatData,
   output logic [KEEP_WIDTH-1:0]        beatKeep,
   output ctsf_frame_t                  beatFrame,
   // Status
   output logic                         protoErr
);

   // Refused while elaborating; the packed beat type fixes the layout
   if (DATA_WIDTH != DATA_W || KEEP_WIDTH != KEEP_W) begin : g_bad_layout
      $error("ctsf_framer: only the 512-bit, 16-Dword layout is served");
   end

   typedef struct packed {
      ctsf_state_t pktState;
      logic        protoErr;
   } ctsf_top_state_t;

   ctsf_top_state_t topReg;
   ctsf_top_state_t topNext;

   ctsf_frame_t decFrame;
   ctsf_beat_t  inBeat;
   ctsf_beat_t  outBeat;
   logic        decOpen;
   logic        decRsvd;
   logic        decCount;
   logic        bufReady;
   logic        accept;

   assign accept = s_axis_cc_tvalid && bufReady;

   ctsf_frame_decode u_decode (
      .straddleEn    (straddleEn),
      .pktOpen       (topReg.pktState == ST_OPEN),
      .sidebandFrame (completionSideband[FRAME_W-1:0]),
      .beatLast      (s_axis_cc_tlast),
      .beatKeep      (s_axis_cc_tkeep),
      .normFrame     (decFrame),
      .nextOpen      (decOpen),
      .rsvdErr       (decRsvd),
      .countErr      (decCount)
   );

   always_comb begin
      inBeat       = '0;
      inBeat.data  = s_axis_cc_tdata;
      inBeat.keep  = s_axis_cc_tkeep;
      inBeat.frame = decFrame;
   end

   // Packet tracking and error pulse advance only on an accepted beat
   always_comb begin
      topNext          = topReg;
      topNext.protoErr = 1'b0;
      if (accept) begin
         case (topReg.pktState)
            ST_IDLE: topNext.pktState = decOpen ? ST_OPEN : ST_IDLE;
            ST_OPEN: topNext.pktState = decOpen ? ST_OPEN : ST_IDLE;
            default: topNext.pktState = ST_IDLE;
         endcase
         topNext.protoErr = decRsvd || decCount;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         topReg.pktState <= ST_IDLE;
         topReg.protoErr <= RST_PROTO_ERR;
      end else begin
         topReg <= topNext;
      end
   end

   // Buffer absorbs a downstream stall without losing an accepted beat
   ctsf_skid_buf #(
      .WIDTH ($bits(ctsf_beat_t))
   ) u_buf (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .inValid  (s_axis_cc_tvalid),
      .inReady  (bufReady),
      .inData   (inBeat),
      .outValid (beatValid),
      .outReady (beatReady),
      .outData  (outBeat)
   );

   assign s_axis_cc_tready = {4{bufReady}};
   assign beatData         = outBeat.data;
   assign beatKeep         = outBeat.keep;
   assign beatFrame        = outBeat.frame;
   assign protoErr         = topReg.protoErr;

   // Helper: what the sideband itself carried on this beat
   logic [1:0] sbStart;
   logic [1:0] sbEnd;
   assign sbStart = completionSideband[START_FLAGS_LSB +: 2];
   assign sbEnd   = completionSideband[END_FLAGS_LSB +: 2];

   chk_nostr_first_beat: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !straddleEn) |->
         decFrame.tlpStartFlags[0] == (topReg.pktState == ST_IDLE)
         && decFrame.tlpStartFlags[1] == 1'b0)
      else $error("start flag not derived from previous last beat");

   chk_nostr_after_last: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !straddleEn && s_axis_cc_tlast) ##1 (accept && !straddleEn) |->
         decFrame.tlpStartFlags == CNT_ONE)
      else $error("beat after last not marked as first beat");

   chk_nostr_lane_zero: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !straddleEn) |->
         decFrame.firstStartPosition == POS_LANE0 && decFrame.secondStartPosition == POS_LANE0)
      else $error("start position not forced to lane 0");

   chk_nostr_end_keep: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !straddleEn && s_axis_cc_tlast && s_axis_cc_tkeep == 16'h00ff) |->
         decFrame.tlpEndFlags == CNT_ONE && decFrame.firstEndOffset == 4'h7)
      else $error("end offset not taken from keep bits");

   chk_nostr_end_ignore: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !straddleEn && !s_axis_cc_tlast) |->
         decFrame.tlpEndFlags == CNT_NONE && topNext.pktState == ST_OPEN)
      else $error("sideband end flags leaked through without straddle");

   chk_str_sideband: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn) |->
         decFrame.tlpStartFlags == sbStart && decFrame.tlpEndFlags == sbEnd
         && decFrame.firstEndOffset == completionSideband[FIRST_END_LSB +: 4]
         && decFrame.secondEndOffset == completionSideband[SECOND_END_LSB +: 4])
      else $error("straddle framing not taken from sideband");

   chk_str_two_starts: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn && sbStart == CNT_TWO
       && completionSideband[SECOND_START_LSB +: 2] != POS_LANE32) |=> protoErr)
      else $error("bad second start position not flagged");

   chk_str_rsvd_code: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn && (sbStart == CNT_RSVD || sbEnd == CNT_RSVD)) |=> protoErr)
      else $error("reserved count code not flagged");

   chk_str_open_track: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn && topReg.pktState == ST_IDLE && sbStart == CNT_ONE
       && sbEnd == CNT_NONE && completionSideband[FIRST_START_LSB] == 1'b0)
      |=> topReg.pktState == ST_OPEN && !protoErr)
      else $error("single start without end did not open a TLP");

   chk_err_quiet: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      !accept |=> !protoErr)
      else $error("error pulse without an accepted beat");

   chk_buf_pass: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !beatValid) |=> beatValid && beatFrame == $past(decFrame))
      else $error("accepted beat not presented next cycle");

   chk_ready_hold: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (beatValid && !beatReady && !s_axis_cc_tready[0]) |=> $stable(beatData))
      else $error("stalled output changed while buffer full");

   chk_str_close_none: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn && topReg.pktState == ST_IDLE && sbStart == CNT_NONE
       && sbEnd == CNT_ONE) |=> protoErr && topReg.pktState == ST_IDLE)
      else $error("end without an open TLP not flagged");

   chk_str_first_pos: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn && sbStart != CNT_NONE
       && completionSideband[FIRST_START_LSB] == 1'b1) |=> protoErr)
      else $error("reserved first start position not flagged");

   chk_str_hand_over: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && straddleEn && topReg.pktState == ST_OPEN && sbStart == CNT_ONE
       && sbEnd == CNT_ONE && completionSideband[FIRST_START_LSB +: 2] == POS_LANE32)
      |=> topReg.pktState == ST_OPEN && !protoErr)
      else $error("closing and opening in one beat not tracked");

   chk_nostr_no_err: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      (accept && !straddleEn) |=> !protoErr)
      else $error("error raised without straddle");

   // Reset must leave the stream ready and the output side empty
   chk_reset_clear: assert property (
      @(posedge sys_clk)
      !rst_b |=> !beatValid && s_axis_cc_tready[0] && !protoErr
         && topReg.pktState == ST_IDLE)
      else $error("reset did not clear the framer");

endmodule : ctsf_framer

/* pkg/ctsf_pkg.sv */
// Shared constants, field layout and decode helpers for the completion framer.
// Assumes a 512-bit completion stream with 16 Dword keep bits, one clock domain.
package ctsf_pkg;

   // Stream geometry
   localparam int DATA_W     = 512;
   localparam int KEEP_W     = 16;
   localparam int SIDEBAND_W = 183;
   localparam int FRAME_W    = 16;

   // Framing field positions within the completion sideband
   localparam int START_FLAGS_LSB  = 0;
   localparam int FIRST_START_LSB  = 2;
   localparam int SECOND_START_LSB = 4;
   localparam int END_FLAGS_LSB    = 6;
   localparam int FIRST_END_LSB    = 8;
   localparam int SECOND_END_LSB   = 12;

   // Start and end count codes
   localparam logic [1:0] CNT_NONE = 2'h0;
   localparam logic [1:0] CNT_ONE  = 2'h1;
   localparam logic [1:0] CNT_RSVD = 2'h2;
   localparam logic [1:0] CNT_TWO  = 2'h3;

   // Start position codes
   localparam logic [1:0] POS_LANE0  = 2'h0;
   localparam logic [1:0] POS_LANE32 = 2'h2;

   // Reset values
   localparam logic RST_PROTO_ERR = 1'b0;

   typedef struct packed {
      logic [3:0] secondEndOffset;
      logic [3:0] firstEndOffset;
      logic [1:0] tlpEndFlags;
      logic [1:0] secondStartPosition;
      logic [1:0] firstStartPosition;
      logic [1:0] tlpStartFlags;
   } ctsf_frame_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [KEEP_W-1:0] keep;
      ctsf_frame_t       frame;
   } ctsf_beat_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_OPEN = 1'b1
   } ctsf_state_t;

   // Number of TLPs a start or end code announces; reserved reads as none
   function automatic logic [1:0] ctsf_count(input logic [1:0] code);
      logic [1:0] n;
      n = 2'h0;
      case (code)
         CNT_ONE: n = 2'h1;
         CNT_TWO: n = 2'h2;
         default: n = 2'h0;
      endcase
      return n;
   endfunction : ctsf_count

   function automatic logic ctsf_count_rsvd(input logic [1:0] code);
      return code == CNT_RSVD;
   endfunction : ctsf_count_rsvd

   // Index of the highest kept Dword, zero when nothing is kept
   function automatic logic [3:0] ctsf_last_dword(input logic [KEEP_W-1:0] keep);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = 0; i < KEEP_W; i++) begin
         if (keep[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : ctsf_last_dword

endpackage : ctsf_pkg

/* core/ctsf_skid_buf.sv */
// Two-entry buffer with valid/ready on both sides and registered outputs.
// Assumes the drain side may stall at any time; a full buffer drops ready.
module ctsf_skid_buf
   import ctsf_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   // Refused while elaborating, before any cycle runs
   if (WIDTH < 1) begin : g_bad_width
      $error("ctsf_skid_buf: WIDTH must be positive");
   end

   typedef struct packed {
      logic             mainValid;
      logic             skidValid;
      logic [WIDTH-1:0] mainWord;
      logic [WIDTH-1:0] skidWord;
   } ctsf_buf_state_t;

   ctsf_buf_state_t bufReg;
   ctsf_buf_state_t bufNext;

   always_comb begin
      bufNext = bufReg;
      if (bufReg.mainValid && outReady) begin
         if (bufReg.skidValid) begin
            bufNext.mainWord  = bufReg.skidWord;
            bufNext.skidValid = 1'b0;
         end else begin
            bufNext.mainValid = 1'b0;
         end
      end
      // Ready is the registered empty skid slot, so no combinational path back
      if (inValid && !bufReg.skidValid) begin
         if (!bufNext.mainValid) begin
            bufNext.mainWord  = inData;
            bufNext.mainValid = 1'b1;
         end else begin
            bufNext.skidWord  = inData;
            bufNext.skidValid = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         bufReg <= '0;
      end else begin
         bufReg <= bufNext;
      end
   end

   assign inReady  = !bufReg.skidValid;
   assign outValid = bufReg.mainValid;
   assign outData  = bufReg.mainWord;

endmodule : ctsf_skid_buf

/* core/ctsf_frame_decode.sv */
// Per-beat framing decode: turns either sideband or last/keep into one frame form.
// Assumes the caller supplies whether a TLP is still open from earlier beats.
module ctsf_frame_decode
   import ctsf_pkg::*;
(
   // Mode and open-packet context
   input  wire logic                  straddleEn,
   input  wire logic                  pktOpen,
   // Beat framing inputs
   input  wire logic [FRAME_W-1:0]    sidebandFrame,
   input  wire logic                  beatLast,
   input  wire logic [KEEP_W-1:0]     beatKeep,
   // Normalised result
   output ctsf_frame_t                normFrame,
   output logic                       nextOpen,
   output logic                       rsvdErr,
   output logic                       countErr
);

   logic [1:0] startCode;
   logic [1:0] firstPos;
   logic [1:0] secondPos;
   logic [1:0] endCode;
   logic [2:0] openSum;

   assign startCode = sidebandFrame[START_FLAGS_LSB +: 2];
   assign firstPos  = sidebandFrame[FIRST_START_LSB +: 2];
   assign secondPos = sidebandFrame[SECOND_START_LSB +: 2];
   assign endCode   = sidebandFrame[END_FLAGS_LSB +: 2];

   always_comb begin
      normFrame = '0;
      nextOpen  = 1'b0;
      rsvdErr   = 1'b0;
      countErr  = 1'b0;
      openSum   = 3'h0;
      if (straddleEn) begin
         // Boundaries come from the sideband only; last is disregarded
         normFrame.tlpStartFlags       = startCode;
         normFrame.firstStartPosition  = firstPos;
         normFrame.secondStartPosition = secondPos;
         normFrame.tlpEndFlags         = endCode;
         normFrame.firstEndOffset      = sidebandFrame[FIRST_END_LSB +: 4];
         normFrame.secondEndOffset     = sidebandFrame[SECOND_END_LSB +: 4];
         rsvdErr = ctsf_count_rsvd(startCode) || ctsf_count_rsvd(endCode)
                   || (startCode != CNT_NONE && firstPos != POS_LANE0
                       && firstPos != POS_LANE32)
                   || (startCode == CNT_TWO && secondPos != POS_LANE32);
         openSum  = {2'b00, pktOpen} + {1'b0, ctsf_count(startCode)};
         // Ends close the open TLP before or alongside the new starts
         countErr = (openSum < {1'b0, ctsf_count(endCode)})
                    || (openSum - {1'b0, ctsf_count(endCode)} > 3'h1);
         nextOpen = !countErr && (openSum - {1'b0, ctsf_count(endCode)} == 3'h1);
      end else begin
         // First beat follows a last beat; start always at lane 0
         normFrame.tlpStartFlags      = {1'b0, !pktOpen};
         normFrame.firstStartPosition = POS_LANE0;
         normFrame.tlpEndFlags        = {1'b0, beatLast};
         normFrame.firstEndOffset     = beatLast ? ctsf_last_dword(beatKeep) : 4'h0;
         nextOpen = !beatLast;
      end
   end

endmodule : ctsf_frame_decode

/* dv/ctsf_sender.sv */
// Behavioural user logic that offers completion beats to the framer.
// Assumes the bench calls send and idle only, all driving on the falling edge.
module ctsf_sender
   import ctsf_pkg::*;
(
   // Clock
   input  wire logic                  sys_clk,
   // Completion stream towards the framer
   input  wire logic [3:0]            s_axis_cc_tready,
   output logic [DATA_W-1:0]          s_axis_cc_tdata,
   output logic [KEEP_W-1:0]          s_axis_cc_tkeep,
   output logic                       s_axis_cc_tlast,
   output logic                       s_axis_cc_tvalid,
   output logic [SIDEBAND_W-1:0]      completionSideband
);
   timeunit 1ns;
   timeprecision 1ps;

   int gapMax = 0;

   initial begin
      s_axis_cc_tdata    = '0;
      s_axis_cc_tkeep    = '0;
      s_axis_cc_tlast    = 1'b0;
      s_axis_cc_tvalid   = 1'b0;
      completionSideband = '0;
   end

   // Idle lines toggle so a stale beat can never match by luck
   task automatic idle();
      @(negedge sys_clk);
      s_axis_cc_tvalid   = 1'b0;
      s_axis_cc_tdata    = ~s_axis_cc_tdata;
      s_axis_cc_tkeep    = ~s_axis_cc_tkeep;
      s_axis_cc_tlast    = ~s_axis_cc_tlast;
      completionSideband = ~completionSideband;
   endtask : idle

   // Beat held until tready is seen high at a rising edge
   task automatic send(input ctsf_beat_t b, input logic last);
      int gap;
      gap = (gapMax > 0) ? $urandom_range(gapMax, 0) : 0;
      repeat (gap) idle();
      @(negedge sys_clk);
      s_axis_cc_tvalid   = 1'b1;
      s_axis_cc_tdata    = b.data;
      s_axis_cc_tkeep    = b.keep;
      s_axis_cc_tlast    = last;
      completionSideband = {{(SIDEBAND_W-FRAME_W){1'b0}}, b.frame};
      @(posedge sys_clk);
      while (s_axis_cc_tready[0] !== 1'b1) @(posedge sys_clk);
   endtask : send
endmodule : ctsf_sender

/* dv/tb.sv */
// Self-checking bench for the completion framer with a queue-based reference.
// Assumes ctsf_sender as the user logic and a 100 MHz sys_clk.
module tb
   import ctsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  sys_clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic                  straddleEn = 1'b0;
   logic                  beatReady = 1'b0;
   logic [DATA_W-1:0]     tdata;
   logic [KEEP_W-1:0]     tkeep;
   logic                  tlast;
   logic                  tvalid;
   logic [SIDEBAND_W-1:0] sb;
   logic [3:0]            tready;
   logic                  beatValid;
   logic [DATA_W-1:0]     beatData;
   logic [KEEP_W-1:0]     beatKeep;
   ctsf_frame_t           beatFrame;
   logic                  protoErr;
   int                    n_errors = 0;
   int                    checks_done = 0;
   int                    cycles = 0;
   int                    stallPct = 0;
   int                    genOpen = 0;
   ctsf_beat_t            expQ[$];
   logic                  errPend = 1'b0;
   logic                  mOpen = 1'b0;
   int                    st0[4] = '{1, 1, 3, 3};
   int                    st1[4] = '{0, 0, 1, 1};
   int                    en[4] = '{0, 1, 1, 3};
   logic [15:0]           rsv[9] = '{16'h0045, 16'h00c3, 16'h00d3, 16'h00f3, 16'h004d,
                                     16'h0002, 16'h0080, 16'h0023, 16'h0040};

   always #5 sys_clk = ~sys_clk;

   ctsf_framer uut (.sys_clk(sys_clk), .rst_b(rst_b), .straddleEn(straddleEn),
      .s_axis_cc_tdata(tdata), .s_axis_cc_tkeep(tkeep), .s_axis_cc_tlast(tlast),
      .s_axis_cc_tvalid(tvalid), .completionSideband(sb), .s_axis_cc_tready(tready),
      .beatValid(beatValid), .beatReady(beatReady), .beatData(beatData),
      .beatKeep(beatKeep), .beatFrame(beatFrame), .protoErr(protoErr));

   ctsf_sender snd (.sys_clk(sys_clk), .s_axis_cc_tready(tready), .s_axis_cc_tdata(tdata),
      .s_axis_cc_tkeep(tkeep), .s_axis_cc_tlast(tlast), .s_axis_cc_tvalid(tvalid),
      .completionSideband(sb));

   always @(negedge sys_clk) beatReady <= ($urandom_range(99, 0) >= stallPct);

   function automatic int cnt(input logic [1:0] c);
      return (c == 2'h1) ? 1 : (c == 2'h3) ? 2 : 0;
   endfunction : cnt

   function automatic logic [3:0] last_dw(input logic [KEEP_W-1:0] k);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < KEEP_W; i++) if (k[i]) r = 4'(i);
      return r;
   endfunction : last_dw

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic cmp_flag(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask : cmp_flag

   task automatic cmp_beat(input ctsf_beat_t e);
      checks_done++;
      if ({beatData, beatKeep, beatFrame} !== e) begin
         n_errors++;
         $display("[ERR] %0t beat frame %h keep %h, expected %h %h", $time, beatFrame,
                  beatKeep, e.frame, e.keep);
      end
   endtask : cmp_beat

   // Reference model: sees every accepted beat, predicts output beat and error pulse
   always @(posedge sys_clk) begin
      ctsf_frame_t f;
      int          n;
      logic        bad;
      if (rst_b !== 1'b1) begin
         expQ.delete();
         errPend = 1'b0;
         mOpen = 1'b0;
      end else begin
         cmp_flag(protoErr, errPend, "protoErr");
         cmp_flag(tready === {4{tready[0]}}, 1'b1, "tready lanes");
         if (beatValid === 1'b1 && beatReady === 1'b1) begin
            if (expQ.size() == 0) cmp_flag(1'b1, 1'b0, "extra beat");
            else cmp_beat(expQ.pop_front());
         end
         errPend = 1'b0;
         if (tvalid === 1'b1 && tready[0] === 1'b1) begin
            if (straddleEn === 1'b1) begin
               f = sb[FRAME_W-1:0];
               n = int'(mOpen) + cnt(f.tlpStartFlags) - cnt(f.tlpEndFlags);
               bad = f.tlpStartFlags == 2'h2 || f.tlpEndFlags == 2'h2 ||
                     (f.tlpStartFlags != 2'h0 && f.firstStartPosition[0]) ||
                     (f.tlpStartFlags == 2'h3 && f.secondStartPosition != 2'h2) ||
                     n < 0 || n > 1;
               mOpen = (n == 1);
            end else begin
               f = '0;
               f.tlpStartFlags = {1'b0, ~mOpen};
               f.tlpEndFlags = {1'b0, tlast};
               if (tlast) f.firstEndOffset = last_dw(tkeep);
               bad = 1'b0;
               mOpen = ~tlast;
            end
            expQ.push_back({tdata, tkeep, f});
            errPend = bad;
         end
      end
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_errors++;
         end_sim();
      end
   end

   // Plain TLP; framing bits of the sideband are noise the framer must ignore, upper bits are zero
   task automatic send_nos(input int beats);
      ctsf_beat_t b;
      for (int i = 0; i < beats; i++) begin
         b.data = {16{$urandom()}};
         b.keep = (i == beats - 1) ? 16'hffff >> $urandom_range(15, 0) : 16'hffff;
         b.frame = 16'($urandom());
         b.frame.tlpStartFlags[0] = (i == 0);
         snd.send(b, i == beats - 1);
      end
   endtask : send_nos

   // Legal straddle traffic drawn from the start/end table; ends closed
   task automatic send_str(input int beats);
      ctsf_beat_t b;
      int         k;
      int         st;
      for (int i = 0; i < beats || genOpen != 0; i++) begin
         k = $urandom_range(3, 0);
         st = genOpen ? st1[k] : st0[k];
         b.data = {16{$urandom()}};
         b.keep = 16'($urandom());
         b.frame.tlpStartFlags = 2'(st);
         b.frame.firstStartPosition = (genOpen != 0 && st == 1) ? 2'h2 : 2'h0;
         b.frame.secondStartPosition = (st == 3) ? 2'h2 : 2'h0;
         b.frame.tlpEndFlags = 2'(en[k]);
         b.frame.firstEndOffset = (en[k] != 0) ? 4'($urandom()) : 4'h0;
         b.frame.secondEndOffset = (en[k] == 3) ? 4'($urandom()) : 4'h0;
         genOpen = (k == 0 || k == 2);
         snd.send(b, 1'($urandom()));
      end
   endtask : send_str

   task automatic drain();
      int k;
      snd.idle();
      stallPct = 0;
      for (k = 0; k < 200 && expQ.size() > 0; k++) @(negedge sys_clk);
      cmp_flag(expQ.size() == 0, 1'b1, "drain");
   endtask : drain

   initial begin
      ctsf_beat_t b;
      void'($urandom(32'hfe26));
      repeat (20) @(negedge sys_clk);
      rst_b = 1'b1;
      stallPct = 30;
      for (int i = 0; i < 8; i++) send_nos($urandom_range(4, 1));
      snd.gapMax = 2;
      for (int i = 0; i < 4; i++) send_nos($urandom_range(3, 1));
      snd.gapMax = 0;
      drain();
      // Reset inside an open TLP; the next beat must open a new one
      b.data = {16{$urandom()}};
      b.keep = 16'hffff;
      b.frame = '0;
      b.frame.tlpStartFlags = 2'h1;
      snd.send(b, 1'b0);
      snd.idle();
      rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      cmp_flag(tready[0], 1'b1, "ready after reset");
      send_nos(2);
      drain();
      // Fill the buffer until it refuses, then release the stall
      stallPct = 100;
      @(negedge sys_clk);
      send_nos(1);
      send_nos(1);
      snd.idle();
      cmp_flag(tready[0], 1'b0, "full buffer");
      fork
         begin
            repeat (4) @(negedge sys_clk);
            stallPct = 0;
         end
      join_none
      send_nos(1);
      drain();
      straddleEn = 1'b1;
      stallPct = 20;
      send_str(24);
      snd.gapMax = 1;
      send_str(10);
      snd.gapMax = 0;
      // Reserved codes and impossible counts, back to back
      foreach (rsv[i]) begin
         b.data = {16{$urandom()}};
         b.keep = 16'($urandom());
         b.frame = rsv[i];
         snd.send(b, 1'($urandom()));
      end
      drain();
      straddleEn = 1'b0;
      send_nos(3);
      drain();
      end_sim();
   end
endmodule : tb
